// ===== ufc_map.vh
// Register map, field positions, reset values and depths of the UART FIFO control block.
// Included by ufc_top.v and ufc_fifo.v; definitions only.
`ifndef UFC_MAP_VH
`define UFC_MAP_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UFC_ADR_CONTROL    6'h00
`define UFC_ADR_FILL       6'h04
`define UFC_ADR_TX_DATA    6'h08
`define UFC_ADR_RX_DATA    6'h0c
`define UFC_ADR_STATUS     6'h10
`define UFC_ADR_MASK       6'h14
`define UFC_ADR_ENABLE     6'h18

// ----------------------------------------
// Control field positions and reset values
// ----------------------------------------
`define UFC_CTL_RX_TRIG_HI 7
`define UFC_CTL_RX_TRIG_LO 6
`define UFC_CTL_TX_TRIG_HI 5
`define UFC_CTL_TX_TRIG_LO 4
`define UFC_CTL_FLOW       3
`define UFC_CTL_TX_FLUSH   2
`define UFC_CTL_RX_FLUSH   1
`define UFC_CTL_LOOP       0
`define UFC_CTL_RESET      8'h00

// Status bits: 0 rx full, 1 tx empty, 2 rx overrun
`define UFC_ST_RX_FULL     0
`define UFC_ST_TX_EMPTY    1
`define UFC_ST_RX_OVERRUN  2
`define UFC_ST_RESET       3'h0

// Enable bits: 0 transmitter, 1 receiver
`define UFC_EN_TX          0
`define UFC_EN_RX          1

// ----------------------------------------
// Depth, counts and serial timing
// ----------------------------------------
`define UFC_DEPTH          5'h10
`define UFC_PTR_W          4
`define UFC_CNT_W          5
`define UFC_RX_TRIG_0      5'h01
`define UFC_RX_TRIG_1      5'h04
`define UFC_RX_TRIG_2      5'h08
`define UFC_RX_TRIG_3      5'h0e
`define UFC_TX_TRIG_0      5'h08
`define UFC_TX_TRIG_1      5'h04
`define UFC_TX_TRIG_2      5'h02
`define UFC_TX_TRIG_3      5'h01
`define UFC_BIT_CYCLES     8'h10
`define UFC_BIT_HALF       8'h08

`endif

// ===== ufc_fifo.v
// Sixteen byte flip-flop FIFO with occupancy count and synchronous flush.
// Assumes one clock; the parent never pushes when full nor pops when empty.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_map.vh"

module ufc_fifo (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       flush,
    input  wire       push,
    input  wire [7:0] push_data,
    input  wire       pop,
    output wire [7:0] head,
    output reg  [4:0] count
);
    reg [7:0] mem [0:15];
    reg [3:0] wr_ptr;
    reg [3:0] rd_ptr;
    integer   i;

    assign head = mem[rd_ptr];

    // ----------------------------------------
    // Pointers and count; flush wins over traffic
    // ----------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count  <= 5'h00;
        end else if (flush) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            count  <= 5'h00;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 4'h1;
            if (pop)
                rd_ptr <= rd_ptr + 4'h1;
            if (push && !pop)
                count <= count + 5'h01;
            else if (pop && !push)
                count <= count - 5'h01;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 16; i = i + 1)
                mem[i] <= 8'h00;
        end else if (push && !flush) begin
            mem[wr_ptr] <= push_data;
        end
    end
endmodule // ufc_fifo
`default_nettype wire

// ===== ufc_top.v
// UART FIFO control: control and fill-count registers, two FIFOs, a simple
// 8N1 transmitter and receiver, flow control, loopback and interrupts.
// Assumes a classic Wishbone master on clk and asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_map.vh"

module ufc_top (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        standby,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [5:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         wb_err_o,
    input  wire        serial_rx_pin,
    output reg         serial_tx_pin,
    input  wire        clear_to_send_in_b,
    output reg         request_to_send_out_b,
    output reg         irq
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function [4:0] rx_level;
        input [1:0] code;
        begin
            case (code)
                2'h0:    rx_level = `UFC_RX_TRIG_0;
                2'h1:    rx_level = `UFC_RX_TRIG_1;
                2'h2:    rx_level = `UFC_RX_TRIG_2;
                default: rx_level = `UFC_RX_TRIG_3;
            endcase
        end
    endfunction

    function [4:0] tx_level;
        input [1:0] code;
        begin
            case (code)
                2'h0:    tx_level = `UFC_TX_TRIG_0;
                2'h1:    tx_level = `UFC_TX_TRIG_1;
                2'h2:    tx_level = `UFC_TX_TRIG_2;
                default: tx_level = `UFC_TX_TRIG_3;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg  [1:0] rx_sync;
    reg  [1:0] cts_sync;
    reg  [1:0] stby_sync;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_sync   <= 2'h3;
            cts_sync  <= 2'h3;
            stby_sync <= 2'h0;
        end else begin
            rx_sync   <= {rx_sync[0], serial_rx_pin};
            cts_sync  <= {cts_sync[0], clear_to_send_in_b};
            stby_sync <= {stby_sync[0], standby};
        end
    end
    wire       stby = stby_sync[1];

    // ----------------------------------------
    // Registers and bus decode
    // ----------------------------------------
    reg  [7:0] fifo_control;
    reg  [2:0] int_status;
    reg  [2:0] int_mask;
    reg  [1:0] xfer_enable;
    wire [4:0] tx_count;
    wire [4:0] rx_count;
    wire [7:0] rx_head;
    wire [7:0] tx_head;

    wire req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire wr_lo = req && wb_we_i && wb_sel_i[0];
    wire known = (wb_adr_i == `UFC_ADR_CONTROL) || (wb_adr_i == `UFC_ADR_FILL)
              || (wb_adr_i == `UFC_ADR_TX_DATA) || (wb_adr_i == `UFC_ADR_RX_DATA)
              || (wb_adr_i == `UFC_ADR_STATUS)  || (wb_adr_i == `UFC_ADR_MASK)
              || (wb_adr_i == `UFC_ADR_ENABLE);
    wire ctl_wr  = wr_lo && (wb_adr_i == `UFC_ADR_CONTROL);
    // Flushes act while the bit is held and once more on the write itself
    wire tx_flush = stby || fifo_control[`UFC_CTL_TX_FLUSH]
                  || (ctl_wr && wb_dat_i[`UFC_CTL_TX_FLUSH]);
    wire rx_flush = stby || fifo_control[`UFC_CTL_RX_FLUSH]
                  || (ctl_wr && wb_dat_i[`UFC_CTL_RX_FLUSH]);
    // Writes to a full tx FIFO are dropped rather than stalling the bus
    wire tx_push = wr_lo && (wb_adr_i == `UFC_ADR_TX_DATA) && (tx_count != `UFC_DEPTH);
    wire rx_pop  = req && !wb_we_i && (wb_adr_i == `UFC_ADR_RX_DATA) && (rx_count != 5'h00);

    reg  [31:0] next_rdata;
    always @* begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            `UFC_ADR_CONTROL: next_rdata = {24'h000000, fifo_control};
            `UFC_ADR_FILL:    next_rdata = {19'h00000, tx_count, 3'h0, rx_count};
            `UFC_ADR_RX_DATA: next_rdata = {24'h000000, rx_head};
            `UFC_ADR_STATUS:  next_rdata = {29'h00000000, int_status};
            `UFC_ADR_MASK:    next_rdata = {29'h00000000, int_mask};
            `UFC_ADR_ENABLE:  next_rdata = {30'h00000000, xfer_enable};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && known;
            wb_err_o <= req && !known;
            wb_dat_o <= (req && known) ? next_rdata : 32'h0000_0000;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_control <= `UFC_CTL_RESET;
            int_mask     <= 3'h0;
            xfer_enable  <= 2'h0;
        end else if (stby) begin
            fifo_control <= `UFC_CTL_RESET;
        end else begin
            if (ctl_wr)
                fifo_control <= wb_dat_i[7:0];
            if (wr_lo && (wb_adr_i == `UFC_ADR_MASK))
                int_mask <= wb_dat_i[2:0];
            if (wr_lo && (wb_adr_i == `UFC_ADR_ENABLE))
                xfer_enable <= wb_dat_i[1:0];
        end
    end

    // ----------------------------------------
    // FIFOs
    // ----------------------------------------
    reg        rx_done;
    reg  [7:0] rx_byte;
    reg        tx_pop;
    wire       rx_push = rx_done && (rx_count != `UFC_DEPTH);

    ufc_fifo u_tx_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .flush     (tx_flush),
        .push      (tx_push),
        .push_data (wb_dat_i[7:0]),
        .pop       (tx_pop),
        .head      (tx_head),
        .count     (tx_count)
    );

    ufc_fifo u_rx_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .flush     (rx_flush),
        .push      (rx_push),
        .push_data (rx_byte),
        .pop       (rx_pop),
        .head      (rx_head),
        .count     (rx_count)
    );

    // ----------------------------------------
    // Flow control and loopback
    // ----------------------------------------
    wire flow_on = fifo_control[`UFC_CTL_FLOW];
    wire cts_ok  = !flow_on || !cts_sync[1];
    wire rx_line = fifo_control[`UFC_CTL_LOOP] ? serial_tx_pin : rx_sync[1];

    // ----------------------------------------
    // Transmitter: start, 8 data, stop; one bit is 16 clocks
    // ----------------------------------------
    reg  [7:0] tx_tick;
    reg  [3:0] tx_bit;
    reg  [8:0] tx_shift;
    reg        tx_busy;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_tick       <= 8'h00;
            tx_bit        <= 4'h0;
            tx_shift      <= 9'h1ff;
            tx_busy       <= 1'b0;
            tx_pop        <= 1'b0;
            serial_tx_pin <= 1'b1;
        end else begin
            tx_pop <= 1'b0;
            if (!tx_busy) begin
                serial_tx_pin <= 1'b1;
                // Frame starts only when cts permits
                if (xfer_enable[`UFC_EN_TX] && cts_ok && (tx_count != 5'h00)
                    && !tx_pop && !tx_flush) begin
                    tx_busy       <= 1'b1;
                    tx_pop        <= 1'b1;
                    tx_shift      <= {1'b1, tx_head};
                    tx_bit        <= 4'h0;
                    tx_tick       <= 8'h00;
                    serial_tx_pin <= 1'b0;
                end
            end else if (!xfer_enable[`UFC_EN_TX]) begin
                tx_busy       <= 1'b0;
                serial_tx_pin <= 1'b1;
            end else if (tx_tick == `UFC_BIT_CYCLES - 8'h01) begin
                tx_tick <= 8'h00;
                if (tx_bit == 4'h9) begin
                    tx_busy <= 1'b0;
                end else begin
                    serial_tx_pin <= tx_shift[0];
                    tx_shift      <= {1'b1, tx_shift[8:1]};
                    tx_bit        <= tx_bit + 4'h1;
                end
            end else begin
                tx_tick <= tx_tick + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Receiver: samples mid-bit, drops bad stop bit
    // ----------------------------------------
    reg  [7:0] rx_tick;
    reg  [3:0] rx_bit;
    reg        rx_busy;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_tick <= 8'h00;
            rx_bit  <= 4'h0;
            rx_busy <= 1'b0;
            rx_byte <= 8'h00;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (xfer_enable[`UFC_EN_RX] && !rx_line) begin
                    rx_busy <= 1'b1;
                    rx_tick <= 8'h00;
                    rx_bit  <= 4'h0;
                end
            end else if (rx_tick == ((rx_bit == 4'h0) ? `UFC_BIT_HALF : `UFC_BIT_CYCLES)
                                   - 8'h01) begin
                rx_tick <= 8'h00;
                rx_bit  <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && rx_line)
                    rx_busy <= 1'b0;
                else if (rx_bit == 4'h9) begin
                    rx_busy <= 1'b0;
                    rx_done <= rx_line;
                end else if (rx_bit != 4'h0)
                    rx_byte <= {rx_line, rx_byte[7:1]};
            end else begin
                rx_tick <= rx_tick + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Interrupt status: set wins over write-one-to-clear
    // ----------------------------------------
    wire [2:0] events;
    assign events[`UFC_ST_RX_FULL]    = rx_count > rx_level(fifo_control[7:6]);
    assign events[`UFC_ST_TX_EMPTY]   = tx_count < tx_level(fifo_control[5:4]);
    assign events[`UFC_ST_RX_OVERRUN] = rx_done && (rx_count == `UFC_DEPTH);
    wire [2:0] st_clr = (wr_lo && (wb_adr_i == `UFC_ADR_STATUS)) ? wb_dat_i[2:0] : 3'h0;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_status            <= `UFC_ST_RESET;
            irq                   <= 1'b0;
            request_to_send_out_b <= 1'b0;
        end else begin
            int_status <= (int_status & ~st_clr) | events;
            irq        <= |(((int_status & ~st_clr) | events) & int_mask);
            // Rts asks the peer to pause when rx is near full; 0 when disabled
            request_to_send_out_b <= flow_on && (rx_count > rx_level(fifo_control[7:6]));
        end
    end
endmodule // ufc_top
`default_nettype wire

// ===== ufc_top_assertions.sv
// Checker for ufc_top: bus answers, fill count, flow control, interrupt.
// Assumes one Wishbone master that writes with sel[0] set.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_map.vh"
module ufc_top_assertions (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        standby,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        serial_tx_pin,
    input wire logic        clear_to_send_in_b,
    input wire logic        request_to_send_out_b,
    input wire logic        irq
);
    // ----------------------------------------
    // Shadow of control and mask, frame tracker
    // ----------------------------------------
    logic [7:0] ctl_m;
    logic [2:0] mask_m;
    logic [7:0] fr;
    logic       tx_d;
    logic       sb1;
    logic       sb2;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire fill_rd = wb_ack_o && !wb_we_i && wb_adr_i == `UFC_ADR_FILL;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_m <= 8'h00;
            mask_m <= 3'h0;
            fr <= 8'h00;
            tx_d <= 1'b1;
            sb1 <= 1'b0;
            sb2 <= 1'b0;
        end else begin
            sb1 <= standby;
            sb2 <= sb1;
            tx_d <= serial_tx_pin;
            if (sb2)
                ctl_m <= 8'h00;
            else if (take && wb_we_i && wb_adr_i == `UFC_ADR_CONTROL)
                ctl_m <= wb_dat_i[7:0];
            if (take && wb_we_i && wb_adr_i == `UFC_ADR_MASK)
                mask_m <= wb_dat_i[2:0];
            // Data bits fall within a frame; only a fall after 150 clocks is a start
            if (fr != 8'h00)
                fr <= fr - 8'h01;
            else if (tx_d && !serial_tx_pin)
                fr <= 8'h96;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_bus_answer: assert property (take |=> wb_ack_o != wb_err_o)
        else $error("bus request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ctl_readback: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == `UFC_ADR_CONTROL)
        |-> wb_dat_o == {24'h0, ctl_m}) else $error("control read mismatch");
    a_fill_zero_bits: assert property (fill_rd
        |-> wb_dat_o[31:13] == 19'h0 && wb_dat_o[7:5] == 3'h0) else $error("fill spare bits");
    a_fill_range: assert property (fill_rd
        |-> wb_dat_o[12:8] <= 5'h10 && wb_dat_o[4:0] <= 5'h10) else $error("fill above 16");
    a_rts_flow_off: assert property (!ctl_m[3] && !$past(ctl_m[3]) |-> !request_to_send_out_b)
        else $error("rts driven with flow off");
    a_cts_gates_tx: assert property ((fr == 8'h00 && tx_d && !serial_tx_pin && ctl_m[3]
        && $past(ctl_m[3], 6)) |-> !$past(clear_to_send_in_b, 1) || !$past(clear_to_send_in_b, 2)
        || !$past(clear_to_send_in_b, 3) || !$past(clear_to_send_in_b, 4)
        || !$past(clear_to_send_in_b, 5) || !$past(clear_to_send_in_b, 6))
        else $error("frame began while cts high");
    a_irq_masked: assert property (mask_m == 3'h0 && $past(mask_m) == 3'h0 |-> !irq)
        else $error("irq with all masked");
    a_standby_empty: assert property ((standby [*6] ##0 fill_rd) |-> wb_dat_o == 32'h0)
        else $error("fifo not empty in standby");
    c_irq: cover property ($rose(irq));
    c_err: cover property (wb_err_o);
    c_tx_full: cover property (fill_rd && wb_dat_o[12:8] == 5'h10);
endmodule // ufc_top_assertions
bind ufc_top ufc_top_assertions u_chk (.clk(clk), .rst_b(rst_b), .standby(standby),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .serial_tx_pin(serial_tx_pin), .clear_to_send_in_b(clear_to_send_in_b),
    .request_to_send_out_b(request_to_send_out_b), .irq(irq));
`default_nettype wire

// ===== ufc_peer.sv
// Remote serial peer: 8N1 frames of 16 clocks a bit, pacing line driver.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module ufc_peer (
    input  wire logic clk,
    input  wire logic hold,
    input  wire logic tx,
    output var  logic rx,
    output var  logic cts_b
);
    // ----------------------------------------
    // Sender, decoder and pacing
    // ----------------------------------------
    int         rx_n;
    logic [7:0] rx_b;
    initial begin
        rx = 1'b1;
        cts_b = 1'b0;
    end
    always @(posedge clk) begin
        cts_b <= hold;
    end
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx <= f[i];
            repeat (16) @(posedge clk);
        end
    endtask
    // Samples mid bit, LSB first
    initial begin
        rx_n = 0;
        forever begin
            @(negedge tx);
            repeat (24) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                rx_b[i] = tx;
                repeat (16) @(posedge clk);
            end
            rx_n++;
        end
    end
endmodule // ufc_peer
`default_nettype wire

// ===== uart_fifo_control_bench.sv
// Bench for ufc_top: Wishbone master, serial peer, one task a scenario.
// Assumes the checker binds itself to ufc_top.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_map.vh"
module uart_fifo_control_bench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        standby = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic [31:0] rdq;
    logic        ack, err, erq, rx, tx, cts_b, rts_b, irq;
    logic        hold = 1'b0;
    int          fails = 0;
    int          comparisons = 0;
    int          n0;
    logic [4:0]  rt [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    logic [4:0]  tt [4] = '{5'h08, 5'h04, 5'h02, 5'h01};
    always #12.5 clk = ~clk;
    ufc_top DUT (.clk(clk), .rst_b(rst_b), .standby(standby), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err), .serial_rx_pin(rx), .serial_tx_pin(tx),
        .clear_to_send_in_b(cts_b), .request_to_send_out_b(rts_b), .irq(irq));
    ufc_peer P (.clk(clk), .hold(hold), .tx(tx), .rx(rx), .cts_b(cts_b));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        if (n >= 50)
            fails++;
        rdq = dat_o;
        erq = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_rx(input logic [4:0] c);
        int k;
        k = 0;
        do begin
            wb(1'b0, `UFC_ADR_FILL, 32'h0);
            k++;
        end while (rdq[4:0] !== c && k < 2000);
        chk(rdq[4:0], c);
    endtask
    task automatic wait_peer;
        int k;
        k = 0;
        while (P.rx_n == n0 && k < 2000) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic t_reset_rw;
        wb(1'b0, `UFC_ADR_CONTROL, 32'h0);
        chk(rdq, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `UFC_ADR_CONTROL, i == 0 ? 32'ha5 : i == 1 ? 32'h5a : 32'h0);
            wb(1'b0, `UFC_ADR_CONTROL, 32'h0);
            chk(rdq, i == 0 ? 32'ha5 : i == 1 ? 32'h5a : 32'h0);
        end
        wb(1'b0, 6'h3c, 32'h0);
        chk(erq, 1'b1);
    endtask
    task automatic t_tx_trig;
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `UFC_ADR_CONTROL, {26'h0, c[1:0], 4'h4});
            wb(1'b1, `UFC_ADR_CONTROL, {26'h0, c[1:0], 4'h0});
            for (int k = 1; k < tt[c]; k++)
                wb(1'b1, `UFC_ADR_TX_DATA, k);
            for (int k = 0; k < 2; k++) begin
                wb(1'b1, `UFC_ADR_STATUS, 32'h2);
                wb(1'b0, `UFC_ADR_STATUS, 32'h0);
                chk(rdq[1], k == 0);
                wb(1'b1, `UFC_ADR_TX_DATA, 32'h55);
            end
        end
        // One more than the depth: the last write is dropped
        for (int k = 0; k < 15; k++)
            wb(1'b1, `UFC_ADR_TX_DATA, k);
        wb(1'b0, `UFC_ADR_FILL, 32'h0);
        chk(rdq, 32'h1000);
        wb(1'b1, `UFC_ADR_CONTROL, 32'h4);
        wb(1'b0, `UFC_ADR_FILL, 32'h0);
        chk(rdq, 32'h0);
    endtask
    task automatic t_standby;
        wb(1'b1, `UFC_ADR_CONTROL, 32'hf8);
        wb(1'b1, `UFC_ADR_TX_DATA, 32'h11);
        standby <= 1'b1;
        repeat (6) @(posedge clk);
        wb(1'b0, `UFC_ADR_FILL, 32'h0);
        chk(rdq, 32'h0);
        wb(1'b0, `UFC_ADR_CONTROL, 32'h0);
        chk(rdq, 32'h0);
        standby <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_rx_loop;
        wb(1'b1, `UFC_ADR_ENABLE, 32'h3);
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `UFC_ADR_CONTROL, {24'h0, c[1:0], 6'h03});
            wb(1'b1, `UFC_ADR_CONTROL, {24'h0, c[1:0], 6'h01});
            for (int k = 0; k < rt[c]; k++)
                wb(1'b1, `UFC_ADR_TX_DATA, k);
            for (int k = 0; k < 2; k++) begin
                wait_rx(rt[c] + k);
                wb(1'b1, `UFC_ADR_STATUS, 32'h1);
                wb(1'b0, `UFC_ADR_STATUS, 32'h0);
                chk(rdq[0], k == 1);
                wb(1'b1, `UFC_ADR_TX_DATA, 32'h77);
            end
            wait_rx(rt[c] + 5'h02);
        end
        // A seventeenth byte overruns the full receive FIFO and is dropped
        wb(1'b1, `UFC_ADR_TX_DATA, 32'h99);
        repeat (200) @(posedge clk);
        wait_rx(5'h10);
        wb(1'b0, `UFC_ADR_STATUS, 32'h0);
        chk(rdq[2:0], 3'h7);
        wb(1'b0, `UFC_ADR_RX_DATA, 32'h0);
        chk(rdq[7:0], 8'h00);
        wb(1'b0, `UFC_ADR_RX_DATA, 32'h0);
        chk(rdq[7:0], 8'h01);
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, `UFC_ADR_MASK, k == 0);
            repeat (3) @(posedge clk);
            chk(irq, k == 0);
        end
        wb(1'b1, `UFC_ADR_CONTROL, 32'h2);
        wait_rx(5'h00);
        wb(1'b1, `UFC_ADR_CONTROL, 32'h0);
        wb(1'b1, `UFC_ADR_STATUS, 32'h7);
        wb(1'b1, `UFC_ADR_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
    endtask
    task automatic t_flow;
        // Peer pauses first, so cts has crossed the synchroniser before the push
        hold <= 1'b1;
        wb(1'b1, `UFC_ADR_CONTROL, 32'h6);
        wb(1'b1, `UFC_ADR_CONTROL, 32'h8);
        n0 = P.rx_n;
        wb(1'b1, `UFC_ADR_TX_DATA, 32'h3c);
        repeat (400) @(posedge clk);
        wb(1'b0, `UFC_ADR_FILL, 32'h0);
        chk(rdq[12:8], 5'h01);
        chk(P.rx_n, n0);
        hold <= 1'b0;
        wait_peer;
        chk(P.rx_b, 8'h3c);
        P.send(8'h5e);
        P.send(8'h5f);
        wait_rx(5'h02);
        chk(rts_b, 1'b1);
        wb(1'b1, `UFC_ADR_CONTROL, 32'h0);
        hold <= 1'b1;
        n0 = P.rx_n;
        wb(1'b1, `UFC_ADR_TX_DATA, 32'hc3);
        wait_peer;
        chk(P.rx_b, 8'hc3);
        chk(rts_b, 1'b0);
    endtask
    task automatic finish_test;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_rw;
        t_tx_trig;
        t_standby;
        t_rx_loop;
        t_flow;
        finish_test;
    end
    initial begin
        #1000000;
        fails++;
        finish_test;
    end
endmodule // uart_fifo_control_bench
`default_nettype wire
